// >>> rtl/flame_qualifier.sv
/*
  Compares the sensed flame current against the two proving thresholds.
  Assumes flame samples synchronous to clk and LOW below HIGH.
*/
module flame_qualifier
  import ignition_pkg::*;
#(
  parameter logic [FLAME_W-1:0] LOW  = FLAME_LOW_DEF,
  parameter logic [FLAME_W-1:0] HIGH = FLAME_HIGH_DEF
)
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Sense in, levels out
  input  wire logic [FLAME_W-1:0] current,
  output flame_level_t            level
);

  flame_level_t level_nxt;

  assign level_nxt.low  = (current >= LOW);
  assign level_nxt.high = (current >= HIGH);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      level <= '0;
    else
      level <= level_nxt;
  end

endmodule : flame_qualifier

// >>> rtl/ignition_pkg.sv
/*
  Shared constants and types for the pilot ignition sequencer.
  Assumes a single system clock at the rate given by CLK_HZ.
*/
package ignition_pkg;

  // System clock
  localparam int unsigned CLK_HZ       = 25_000_000;
  // Sequencing tick period in milliseconds
  localparam int unsigned TICK_MS      = 1;
  localparam int unsigned TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

  // Interval lengths, each in its own unit
  localparam int unsigned TRIAL_S      = 90;
  localparam int unsigned STABILIZE_MS = 2000;
  localparam int unsigned RETRY_MIN    = 5;
  localparam int unsigned RESET_S      = 30;

  // Interval lengths in ticks (longest times round down, least times round up)
  localparam int unsigned TRIAL_TICKS     = TRIAL_S * 1000 / TICK_MS;
  localparam int unsigned STABILIZE_TICKS = STABILIZE_MS / TICK_MS;
  localparam int unsigned RETRY_TICKS     = (RETRY_MIN * 60000 + TICK_MS - 1) / TICK_MS;
  localparam int unsigned RESET_TICKS     = (RESET_S * 1000 + TICK_MS - 1) / TICK_MS;

  // Interval counter and prescaler widths
  localparam int unsigned TIMER_W  = 20;
  localparam int unsigned PRESC_W  = 16;

  // Flame current sample width and default thresholds
  localparam int unsigned FLAME_W          = 8;
  localparam logic [FLAME_W-1:0] FLAME_LOW_DEF  = 8'h40;
  localparam logic [FLAME_W-1:0] FLAME_HIGH_DEF = 8'h60;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TRIAL,
    ST_STABILIZE,
    ST_RUN,
    ST_RETRY_WAIT,
    ST_SHUTOFF
  } seq_state_t;

  // Load drives toward valves and spark generator
  typedef struct packed {
    logic spark;
    logic pilot;
    logic main;
  } drive_t;

  // Qualified flame levels
  typedef struct packed {
    logic low;
    logic high;
  } flame_level_t;

  localparam drive_t DRIVE_OFF = 3'h0;

endpackage : ignition_pkg

// >>> rtl/pilot_ignition_sequencer.sv
/*
  Intermittent pilot ignition sequencer: trial, two-level proving,
  stabilization, run-mode flame watch, timed retry and shutoff reset.
  Assumes heat request and flame current synchronous to SYS_CLK,
  power-up reset on RST_N, and load relays driven by the outputs.
*/
// Contract
// - Heat request with no delay running turns spark and pilot on together; spark stays off if flame is already at the lower threshold.
// - Trial lasts at most 90 s; unproven pilot then loses spark.
// - Flame at lower threshold in trial stops spark, pilot stays open.
// - Main valve opens only at the higher flame threshold.
// - Flame dropping below lower threshold before main opens re-arms spark.
// - Re-sparking never stretches the trial beyond its length from start.
// - Main valve opening starts a short stabilization before run mode.
// - Flame loss in run mode closes pilot and main together.
// - Trial expiry without proven pilot turns spark and pilot off.
// - Failed trial waits five minutes with every load drive off.
// - Trial and retry delay repeat until proven or request ends.
// - Removing the request cancels a pending retry delay.
// - After shutoff request must stay off 30 s before a fresh start.
// - Request withdrawal turns pilot, main and spark off in any state.
module pilot_ignition_sequencer
#(
  parameter int unsigned             TICK_DIV   = ignition_pkg::TICK_CYCLES,
  parameter int unsigned             TRIAL_LEN  = ignition_pkg::TRIAL_TICKS,
  parameter int unsigned             STAB_LEN   = ignition_pkg::STABILIZE_TICKS,
  parameter int unsigned             RETRY_LEN  = ignition_pkg::RETRY_TICKS,
  parameter int unsigned             RESET_LEN  = ignition_pkg::RESET_TICKS,
  parameter logic [ignition_pkg::FLAME_W-1:0] FLAME_LOW  = ignition_pkg::FLAME_LOW_DEF,
  parameter logic [ignition_pkg::FLAME_W-1:0] FLAME_HIGH = ignition_pkg::FLAME_HIGH_DEF
)
(
  // Clock and reset
  input  wire logic                             SYS_CLK,
  input  wire logic                             RST_N,
  // Thermostat and flame sense
  input  wire logic                             HEAT_REQUEST_INPUT,
  input  wire logic [ignition_pkg::FLAME_W-1:0] FLAME_CURRENT,
  // Load drives
  output logic                                  SPARK_DRIVE,
  output logic                                  PILOT_VALVE_DRIVE,
  output logic                                  MAIN_VALVE_DRIVE,
  // Status
  output logic                                  RUN_MODE,
  output logic                                  RETRY_PENDING,
  output logic                                  SHUTOFF_LOCKED
);
  import ignition_pkg::*;

  seq_state_t          state_r;
  seq_state_t          state_nxt;
  logic [TIMER_W-1:0]  timer_r;
  logic [TIMER_W-1:0]  timer_nxt;
  drive_t              drive_r;
  drive_t              drive_nxt;
  flame_level_t        flame;
  logic                tick;
  logic                heat;

  // Interval end: the tick that brings the count to its limit
  function automatic logic ends(input logic [TIMER_W-1:0] t, input int unsigned len,
                                input logic tk);
    ends = tk && (t == TIMER_W'(len - 1));
  endfunction : ends

  tick_prescaler #(
    .DIVIDE (TICK_DIV)
  ) u_tick (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .tick  (tick)
  );

  flame_qualifier #(
    .LOW  (FLAME_LOW),
    .HIGH (FLAME_HIGH)
  ) u_flame (
    .clk     (SYS_CLK),
    .rst_n   (RST_N),
    .current (FLAME_CURRENT),
    .level   (flame)
  );

  assign heat = HEAT_REQUEST_INPUT;

  wire trial_end  = ends(timer_r, TRIAL_LEN, tick);
  wire stab_end   = ends(timer_r, STAB_LEN, tick);
  wire retry_end  = ends(timer_r, RETRY_LEN, tick);
  wire reset_end  = ends(timer_r, RESET_LEN, tick);

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
        if (heat)
          state_nxt = ST_TRIAL;
      ST_TRIAL:
        if (!heat)
          state_nxt = ST_IDLE;
        else if (flame.high)
          state_nxt = ST_STABILIZE;
        else if (trial_end)
          state_nxt = ST_RETRY_WAIT;
      ST_STABILIZE:
        if (!heat)
          state_nxt = ST_IDLE;
        else if (stab_end)
          state_nxt = ST_RUN;
      ST_RUN:
        if (!heat)
          state_nxt = ST_IDLE;
        else if (!flame.low)
          state_nxt = ST_SHUTOFF;
      ST_RETRY_WAIT:
        if (!heat)
          state_nxt = ST_IDLE;
        else if (retry_end)
          state_nxt = ST_TRIAL;
      ST_SHUTOFF:
        if (!heat && reset_end)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // Interval counter restarts on every state change and while waiting out a request
  always_comb
  begin
    if (state_nxt != state_r)
      timer_nxt = '0;
    else if (state_r == ST_SHUTOFF && heat)
      timer_nxt = '0;
    else if (tick)
      timer_nxt = timer_r + TIMER_W'(1);
    else
      timer_nxt = timer_r;
  end

  // Load drives follow the next state
  always_comb
  begin
    drive_nxt = DRIVE_OFF;
    unique case (state_nxt)
      ST_TRIAL:
      begin
        drive_nxt.pilot = 1'b1;
        drive_nxt.spark = !flame.low;
      end
      ST_STABILIZE, ST_RUN:
      begin
        drive_nxt.pilot = 1'b1;
        drive_nxt.main  = 1'b1;
      end
      default:
        drive_nxt = DRIVE_OFF;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      timer_r <= '0;
    else
      timer_r <= timer_nxt;
  end

  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
      drive_r <= DRIVE_OFF;
    else
      drive_r <= drive_nxt;
  end

  // Status flags
  always_ff @(posedge SYS_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RUN_MODE       <= 1'b0;
      RETRY_PENDING  <= 1'b0;
      SHUTOFF_LOCKED <= 1'b0;
    end
    else
    begin
      RUN_MODE       <= (state_nxt == ST_RUN);
      RETRY_PENDING  <= (state_nxt == ST_RETRY_WAIT);
      SHUTOFF_LOCKED <= (state_nxt == ST_SHUTOFF);
    end
  end

  assign SPARK_DRIVE       = drive_r.spark;
  assign PILOT_VALVE_DRIVE = drive_r.pilot;
  assign MAIN_VALVE_DRIVE  = drive_r.main;

  // Checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  chk_trial_start: assert property (
    (state_r == ST_IDLE && heat)
      |=> (SPARK_DRIVE == !$past(flame.low)) && PILOT_VALVE_DRIVE)
    else $error("trial did not start spark and pilot");

  chk_trial_bound: assert property (
    (state_r == ST_TRIAL) |-> (timer_r < TIMER_W'(TRIAL_LEN)))
    else $error("trial ran past its length");

  chk_expiry_off: assert property (
    (state_r == ST_TRIAL && heat && trial_end && !flame.high)
      |=> !SPARK_DRIVE && !PILOT_VALVE_DRIVE && RETRY_PENDING)
    else $error("expired trial left spark or pilot on");

  chk_low_stops_spark: assert property (
    (state_r == ST_TRIAL && heat && flame.low && !flame.high && !trial_end)
      |=> !SPARK_DRIVE && PILOT_VALVE_DRIVE)
    else $error("lower flame level did not stop spark");

  chk_main_needs_high: assert property (
    $rose(MAIN_VALVE_DRIVE) |-> $past(flame.high) && $past(state_r) == ST_TRIAL)
    else $error("main valve opened without high flame");

  chk_interlock: assert property (
    MAIN_VALVE_DRIVE |-> PILOT_VALVE_DRIVE && !SPARK_DRIVE)
    else $error("main valve interlock broken");

  chk_loss_shutoff: assert property (
    (state_r == ST_RUN && heat && !flame.low)
      |=> !PILOT_VALVE_DRIVE && !MAIN_VALVE_DRIVE ##1 !PILOT_VALVE_DRIVE)
    else $error("flame loss did not close both valves");

  chk_withdraw_off: assert property (
    !heat |=> !SPARK_DRIVE && !PILOT_VALVE_DRIVE && !MAIN_VALVE_DRIVE)
    else $error("withdrawn request left a load on");

  chk_retry_quiet: assert property (
    RETRY_PENDING |-> !SPARK_DRIVE && !PILOT_VALVE_DRIVE && !MAIN_VALVE_DRIVE)
    else $error("load on during retry delay");

  chk_retry_cancel: assert property (
    (state_r == ST_RETRY_WAIT && !heat) |=> state_r == ST_IDLE)
    else $error("retry delay not cancelled");

  chk_reset_hold: assert property (
    (state_r == ST_SHUTOFF && heat) |=> state_r == ST_SHUTOFF && timer_r == '0)
    else $error("shutoff released while request present");

  chk_stab_run: assert property (
    (state_r == ST_STABILIZE && heat && stab_end) |=> RUN_MODE && MAIN_VALVE_DRIVE)
    else $error("stabilization did not enter run mode");

  chk_respark: assert property (
    (state_r == ST_TRIAL && heat && !flame.low && !flame.high && !trial_end)
      |=> SPARK_DRIVE && PILOT_VALVE_DRIVE)
    else $error("weak flame did not re-arm spark");

  chk_spark_pilot: assert property (
    SPARK_DRIVE |-> PILOT_VALVE_DRIVE)
    else $error("spark on without pilot gas");

  chk_idle_quiet: assert property (
    (state_r == ST_IDLE) |-> !SPARK_DRIVE && !PILOT_VALVE_DRIVE && !MAIN_VALVE_DRIVE)
    else $error("load on while idle");

  chk_stab_first: assert property (
    $rose(MAIN_VALVE_DRIVE) |-> !RUN_MODE)
    else $error("run mode began without stabilization");

  chk_run_valves: assert property (
    RUN_MODE |-> PILOT_VALVE_DRIVE && MAIN_VALVE_DRIVE)
    else $error("run mode without both valves open");

  chk_lock_entry: assert property (
    $rose(SHUTOFF_LOCKED) |-> $past(state_r) == ST_RUN)
    else $error("shutoff entered outside run mode");

  chk_lock_quiet: assert property (
    SHUTOFF_LOCKED |-> !SPARK_DRIVE && !PILOT_VALVE_DRIVE && !MAIN_VALVE_DRIVE)
    else $error("load on while shut off");

  chk_lock_release: assert property (
    (state_r == ST_SHUTOFF && !heat && reset_end)
      |=> !SHUTOFF_LOCKED && state_r == ST_IDLE)
    else $error("shutoff not released after withdrawal");

  chk_retry_bound: assert property (
    (state_r == ST_RETRY_WAIT) |-> (timer_r < TIMER_W'(RETRY_LEN)))
    else $error("retry delay ran past its length");

  chk_retry_again: assert property (
    (state_r == ST_RETRY_WAIT && heat && retry_end)
      |=> PILOT_VALVE_DRIVE && !RETRY_PENDING)
    else $error("retry delay did not start a new trial");

  cov_proven: cover property ($rose(RUN_MODE));
  cov_retry: cover property ($fell(RETRY_PENDING) && SPARK_DRIVE);
  cov_respark: cover property ($fell(SPARK_DRIVE) ##[1:20] $rose(SPARK_DRIVE));
  cov_reset: cover property ($fell(SHUTOFF_LOCKED) && !heat);
  cov_cancel: cover property ($fell(RETRY_PENDING) && !PILOT_VALVE_DRIVE);

endmodule : pilot_ignition_sequencer

// >>> rtl/tick_prescaler.sv
/*
  Divides the system clock into a one-cycle sequencing tick.
  Assumes SYS_CLK and an active-low asynchronous reset.
*/
module tick_prescaler
  import ignition_pkg::*;
#(
  parameter int unsigned DIVIDE = TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Tick out
  output logic      tick
);

  logic [PRESC_W-1:0] cnt_r;
  logic               wrap;

  assign wrap = (cnt_r == PRESC_W'(DIVIDE - 1));

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= '0;
    else if (wrap)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + PRESC_W'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tick <= 1'b0;
    else
      tick <= wrap;
  end

endmodule : tick_prescaler

// >>> testbench/flame_source.sv
/*
  Burner model: sensed flame current follows a set level while the pilot valve is open.
  Assumes the pilot drive is sampled on the rising clock edge.
*/
module flame_source
(
  // Clock
  input  wire logic                             clk,
  // Valve drive and wanted level
  input  wire logic                             pilot_on,
  input  wire logic [ignition_pkg::FLAME_W-1:0] level_set,
  // Sensed current
  output logic [ignition_pkg::FLAME_W-1:0]      current
);
  timeunit 1ns;
  timeprecision 1ns;
  import ignition_pkg::*;

  // No pilot gas, no flame
  always_ff @(posedge clk)
  begin
    current <= pilot_on ? level_set : 8'h00;
  end
endmodule : flame_source

// >>> testbench/tb_top.sv
/*
  Self-checking bench for the pilot ignition sequencer with shortened intervals.
  Assumes flame_source stands in for the burner and the bench acts as thermostat.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ignition_pkg::*;

  localparam int DIV = 4;
  localparam int TRL = 20;
  localparam int STB = 3;
  localparam int RTY = 10;
  localparam int RST = 5;

  typedef struct packed {
    logic [7:0] lvl;
    logic       spark;
    logic       main;
  } row_t;

  logic       clk        = 1'b0;
  logic       rst_n      = 1'b0;
  logic       heat       = 1'b0;
  logic [7:0] lvl        = 8'h00;
  logic [7:0] flame;
  logic       spark;
  logic       pilot;
  logic       main;
  logic       run;
  logic       retry;
  logic       locked;
  logic [5:0] mon;
  int         mismatches = 0;
  int         cmp_count  = 0;
  int         n;
  row_t       rows[5]    = '{'{8'h00, 1'b1, 1'b0}, '{8'h40, 1'b0, 1'b0},
                             '{8'h3f, 1'b1, 1'b0}, '{8'h5f, 1'b0, 1'b0},
                             '{8'h60, 1'b0, 1'b1}};

  assign mon = {spark, pilot, main, run, retry, locked};

  always #20 clk = ~clk;

  flame_source burner (.clk(clk), .pilot_on(pilot), .level_set(lvl), .current(flame));

  pilot_ignition_sequencer #(.TICK_DIV(DIV), .TRIAL_LEN(TRL), .STAB_LEN(STB),
    .RETRY_LEN(RTY), .RESET_LEN(RST)) dut (
    .SYS_CLK(clk), .RST_N(rst_n), .HEAT_REQUEST_INPUT(heat), .FLAME_CURRENT(flame),
    .SPARK_DRIVE(spark), .PILOT_VALVE_DRIVE(pilot), .MAIN_VALVE_DRIVE(main),
    .RUN_MODE(run), .RETRY_PENDING(retry), .SHUTOFF_LOCKED(locked));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      mismatches++;
    end
  endtask : chk

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic edges(input int k);
    repeat (k) @(posedge clk);
  endtask : edges

  task automatic look(input int k);
    edges(k);
    #1;
  endtask : look

  // Bounded wait for one status bit to reach a value
  task automatic wait_bit(input int idx, input logic val, input int lim, output int cnt);
    cnt = 0;
    while (mon[idx] !== val && cnt < lim)
    begin
      look(1);
      cnt++;
    end
    if (mon[idx] !== val)
    begin
      $display("Error at %0t: wait on bit %0d ran out", $time, idx);
      mismatches++;
      wrap_up();
    end
  endtask : wait_bit

  initial
  begin
    edges(6);
    rst_n <= 1'b1;
    #1;
    chk(mon, 8'h00);
    edges(1);
    heat <= 1'b1;
    look(2);
    chk(mon, 8'h30);
    // Two-level proving within one trial
    foreach (rows[i])
    begin
      edges(1);
      lvl <= rows[i].lvl;
      look(4);
      chk({spark, main}, {rows[i].spark, rows[i].main});
    end
    wait_bit(2, 1'b1, (STB + 2) * DIV + 4, n);
    chk(n >= (STB - 1) * DIV, 1'b1);
    chk(mon, 8'h1c);
    // Flame loss in run mode
    edges(1);
    lvl <= 8'h00;
    look(4);
    chk(mon, 8'h01);
    // Too short a withdrawal keeps the shutoff
    edges(1);
    heat <= 1'b0;
    edges(2 * DIV);
    heat <= 1'b1;
    look(2 * DIV);
    chk(locked, 1'b1);
    edges(1);
    heat <= 1'b0;
    wait_bit(0, 1'b0, (RST + 2) * DIV + 4, n);
    chk(n >= (RST - 1) * DIV, 1'b1);
    edges(1);
    heat <= 1'b1;
    look(2);
    chk(mon, 8'h30);
    // Weak flame keeps re-sparking until the trial runs out
    n = 0;
    while (pilot === 1'b1 && n < (TRL + 2) * DIV + 8)
    begin
      edges(1);
      n++;
      if (n % 8 == 0)
        lvl <= lvl ^ 8'h50;
      #1;
    end
    chk(n <= (TRL + 1) * DIV + 2, 1'b1);
    chk(n >= (TRL - 1) * DIV, 1'b1);
    chk(mon, 8'h02);
    edges(1);
    lvl <= 8'h00;
    wait_bit(4, 1'b1, (RTY + 2) * DIV + 8, n);
    chk(n >= (RTY - 1) * DIV, 1'b1);
    chk(spark, 1'b1);
    // Withdrawal cancels a pending retry
    wait_bit(4, 1'b0, (TRL + 2) * DIV + 8, n);
    chk(retry, 1'b1);
    edges(1);
    heat <= 1'b0;
    look(2);
    chk(mon, 8'h00);
    edges(1);
    heat <= 1'b1;
    look(2);
    chk(mon, 8'h30);
    // Power cycle during a retry delay starts afresh
    wait_bit(1, 1'b1, (TRL + 2) * DIV + 8, n);
    edges(1);
    rst_n <= 1'b0;
    look(2);
    chk(mon, 8'h00);
    edges(1);
    rst_n <= 1'b1;
    look(2);
    chk(mon, 8'h30);
    edges(1);
    heat <= 1'b0;
    look(2);
    chk(mon, 8'h00);
    wrap_up();
  end
endmodule : tb_top
